// ### pkg/flash_front_consts.vh
`ifndef FLASH_FRONT_CONSTS_VH
`define FLASH_FRONT_CONSTS_VH

// ----------------------------------------
// register offsets on the local port
// ----------------------------------------
`define ADDR_STATUS 4'h0
`define ADDR_FUNCTION 4'h1
`define ADDR_CONTROL 4'h2
`define ADDR_TX_DATA 4'h3
`define ADDR_RX_DATA 4'h4
`define ADDR_PIN_STATE 4'h5

// ----------------------------------------
// status register fields
// ----------------------------------------
`define ST_SWD_BIT 7
`define ST_QE_BIT 6
`define ST_BP_HI 5
`define ST_BP_LO 2
`define STATUS_WMASK 8'hFC
`define STATUS_RESET 8'h00

// ----------------------------------------
// function and control register fields
// ----------------------------------------
`define FUNC_RST_DIS_BIT 0
`define FUNC_RESET 8'h00
`define CTL_PFS_BIT 0
`define CTL_MODE_HI 2
`define CTL_MODE_LO 1
`define CTL_DIR_BIT 3
`define CONTROL_RESET 8'h00

// ----------------------------------------
// pin state register fields
// ----------------------------------------
`define PS_SELECTED_BIT 0
`define PS_PAUSED_BIT 1
`define PS_RESET_BIT 2
`define PS_RX_FULL_BIT 3
`define PS_REFUSED_BIT 4

// ----------------------------------------
// lane modes and transfer sizes
// ----------------------------------------
`define MODE_SINGLE 2'h0
`define MODE_DUAL 2'h1
`define MODE_QUAD 2'h2
`define BYTE_BITS 4'h8
`define TX_RESET 8'hFF

`endif

// ### verilog/pin_sync.v
`timescale 1ns/1ps

// two-stage synchroniser for pins from outside the system clock
module pin_sync
#(
   parameter W = 7,
   parameter [W-1:0] INIT = {W{1'b0}}
)
(
   // clock, reset, enable
   input wire i_sys_clk,
   input wire i_resetn,
   input wire i_ce,
   // raw pins and their synchronised copy
   input wire [W-1:0] i_async,
   output reg [W-1:0] o_sync
);

// first stage, read by the second stage only
reg [W-1:0] meta;

// ----------------------------------------
// two flip-flops per bit
// ----------------------------------------
always @(posedge i_sys_clk or negedge i_resetn)
begin
   if (!i_resetn)
   begin
      meta <= INIT;
      o_sync <= INIT;
   end
   else if (i_ce)
   begin
      meta <= i_async;
      o_sync <= meta;
   end
end

endmodule // pin_sync

// ### verilog/lane_shifter.v
`timescale 1ns/1ps
`include "flash_front_consts.vh"

// byte shifter for one, two or four lanes, msb first
module lane_shifter
(
   // clock, reset, enable
   input wire i_sys_clk,
   input wire i_resetn,
   input wire i_ce,
   // control from the frame logic
   input wire i_clear,
   input wire i_sample,
   input wire i_advance,
   input wire [2:0] i_step,
   input wire [7:0] i_load_data,
   input wire [3:0] i_lanes,
   // results
   output reg [7:0] o_rx_byte,
   output reg o_rx_done,
   output wire [3:0] o_tx_bits
);

reg [7:0] rx_sh; // receive shift register
reg [3:0] rx_cnt; // bits taken in this byte
reg [7:0] tx_sh; // transmit shift register
reg [3:0] tx_cnt; // bits sent in this byte
wire [3:0] step4; // step widened for counters
wire [7:0] next_rx; // receive value after this edge

// shift a register left by the lane count, filling from the lanes
function [7:0] shift_lanes;
   input [7:0] v;
   input [3:0] lanes;
   input [2:0] n;
   begin
      case (n)
         3'h2: shift_lanes = {v[5:0], lanes[1:0]};
         3'h4: shift_lanes = {v[3:0], lanes};
         default: shift_lanes = {v[6:0], lanes[0]};
      endcase
   end
endfunction

assign step4 = {1'b0, i_step};
assign next_rx = shift_lanes(rx_sh, i_lanes, i_step);
// top bits always lead; the top module picks the lanes
assign o_tx_bits = tx_sh[7:4];

// ----------------------------------------
// receive side, rising edges
// ----------------------------------------
always @(posedge i_sys_clk or negedge i_resetn)
begin
   if (!i_resetn)
   begin
      rx_sh <= 8'h00;
      rx_cnt <= 4'h0;
      o_rx_byte <= 8'h00;
      o_rx_done <= 1'b0;
   end
   else if (i_ce)
   begin
      o_rx_done <= 1'b0;
      if (i_clear)
      begin
         // a new frame starts on a byte boundary
         rx_cnt <= 4'h0;
      end
      else if (i_sample)
      begin
         rx_sh <= next_rx;
         if (rx_cnt + step4 == `BYTE_BITS)
         begin
            o_rx_byte <= next_rx;
            o_rx_done <= 1'b1;
            rx_cnt <= 4'h0;
         end
         else
         begin
            rx_cnt <= rx_cnt + step4;
         end
      end
   end
end

// ----------------------------------------
// transmit side, falling edges
// ----------------------------------------
always @(posedge i_sys_clk or negedge i_resetn)
begin
   if (!i_resetn)
   begin
      tx_sh <= `TX_RESET;
      tx_cnt <= 4'h0;
   end
   else if (i_ce)
   begin
      if (i_clear)
      begin
         tx_sh <= i_load_data;
         tx_cnt <= 4'h0;
      end
      else if (i_advance)
      begin
         if (tx_cnt + step4 == `BYTE_BITS)
         begin
            // reload so the next byte's msb is out on this edge
            tx_sh <= i_load_data;
            tx_cnt <= 4'h0;
         end
         else
         begin
            tx_sh <= shift_lanes(tx_sh, 4'h0, i_step);
            tx_cnt <= tx_cnt + step4;
         end
      end
   end
end

endmodule // lane_shifter

// ### verilog/flash_pin_front_end.v
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "flash_front_consts.vh"

// Overview of operation
// - select high: deselected, all outputs released
// - select high: serial input bits ignored
// - instruction only after select falls from high
// - single lane: sample input on clock rise
// - single lane: drive output on clock fall
// - dual/quad: lanes bidirectional, rise in, fall out
// - quad uses protect and hold pins as lanes
// - protect pin low with lock: status writes refused
// - lock bit clear: status writes always allowed
// - quad enable: protect pin is only lane two
// - quad enable: fourth pin is only lane three
// - no reset pin: control pin-function bit picks hold/reset
// - reset pin enabled: fourth pin is hold
// - reset pin disabled: control pin-function bit picks hold/reset
// - hold low while selected pauses, keeps progress
// - hold and select low: output released
// - hold high resumes exactly where it paused
// - reset low: outputs released, normal on release
// - function bit zero set disables reset pin
module flash_pin_front_end
#(
   parameter HAS_RESET_PIN = 1 // package has a dedicated reset pin
)
(
   // clock, reset, enable
   input wire i_sys_clk,
   input wire i_resetn,
   input wire i_ce,
   // serial link pins
   input wire i_sck,
   input wire i_select_n,
   input wire i_reset_pin_n,
   input wire [3:0] i_data_lane_in,
   output reg [3:0] o_data_lane_out,
   output reg [3:0] o_data_lane_oe,
   // register port
   input wire [3:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata,
   // received byte strobe
   output reg o_rx_strobe
);

// ----------------------------------------
// frame states, one-hot
// ----------------------------------------
localparam [3:0] S_IDLE = 4'b0001; // deselected
localparam [3:0] S_ACTIVE = 4'b0010; // selected, shifting
localparam [3:0] S_PAUSED = 4'b0100; // held, progress kept
localparam [3:0] S_RESET = 4'b1000; // pin reset asserted

// ----------------------------------------
// declarations
// ----------------------------------------
wire [6:0] pins_s; // synchronised pins
wire sck_s; // clock pin, system domain
wire sel_n_s; // select pin, system domain
wire rst_pin_n_s; // dedicated reset pin
wire [3:0] lane_s; // data lanes, system domain
reg sck_d; // last sampled clock level
reg sel_n_d; // last sampled select level
wire sck_rise; // link clock rising edge
wire sck_fall; // link clock falling edge
wire sel_fall; // select high-to-low transition
reg [3:0] state; // frame state
reg [3:0] next_state; // next frame state
reg [7:0] status; // protection and quad bits
reg [7:0] func; // function register
reg [7:0] control; // lane mode, direction, pin function
reg [7:0] tx_data; // byte sent on read phases
reg [7:0] rx_data; // last byte received
reg rx_full; // unread received byte
reg refused; // a status write was refused
reg seen_rise; // one rising edge seen in the frame
wire qe; // quad enable
wire swd; // status write disable
wire rst_pin_en; // dedicated reset pin in use
wire fourth_is_hold; // fourth pin acts as hold
wire fourth_is_reset; // fourth pin acts as reset
wire reset_req; // any pin reset asserted
wire hold_req; // hold asserted
wire wp_lock; // status register locked
wire [1:0] mode_raw; // requested lane mode
wire [1:0] mode; // lane mode in effect
wire [2:0] step; // bits moved per clock edge
wire drive; // device drives the lanes now
wire shift_clear; // restart the shifter
wire sample_en; // take a rising edge
wire advance_en; // take a falling edge
wire [7:0] rx_byte; // byte from the shifter
wire rx_done; // byte completed
wire [3:0] tx_bits; // bits leading the tx byte
reg [3:0] next_oe; // lane enables next cycle
reg [3:0] next_out; // lane levels next cycle
reg [7:0] next_rdata; // read data next cycle

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
// reset pin resets high; select resets low so only a real high-then-low counts
pin_sync
#(
   .W(7),
   .INIT(7'h04)
)
u_sync
(
   .i_sys_clk(i_sys_clk),
   .i_resetn(i_resetn),
   .i_ce(i_ce),
   .i_async({i_data_lane_in, i_reset_pin_n, i_select_n, i_sck}),
   .o_sync(pins_s)
);

assign sck_s = pins_s[0];
assign sel_n_s = pins_s[1];
assign rst_pin_n_s = pins_s[2];
assign lane_s = pins_s[6:3];

// ----------------------------------------
// edge detection on the link clock and select
// ----------------------------------------
always @(posedge i_sys_clk or negedge i_resetn)
begin
   if (!i_resetn)
   begin
      sck_d <= 1'b0;
      // low after reset: select must rise before a fall counts
      sel_n_d <= 1'b0;
   end
   else if (i_ce)
   begin
      sck_d <= sck_s;
      sel_n_d <= sel_n_s;
   end
end

assign sck_rise = sck_s & ~sck_d;
assign sck_fall = ~sck_s & sck_d;
assign sel_fall = ~sel_n_s & sel_n_d;

// ----------------------------------------
// pin function decoding
// ----------------------------------------
assign qe = status[`ST_QE_BIT];
assign swd = status[`ST_SWD_BIT];
assign rst_pin_en = (HAS_RESET_PIN != 0) && !func[`FUNC_RST_DIS_BIT];
// fourth pin: data only in quad, else hold unless reset chosen
assign fourth_is_hold = !qe && (rst_pin_en || !control[`CTL_PFS_BIT]);
assign fourth_is_reset = !qe && !fourth_is_hold;
// both reset sources share one effect
assign reset_req = (rst_pin_en && !rst_pin_n_s) || (fourth_is_reset && !lane_s[3]);
assign hold_req = fourth_is_hold && !lane_s[3];
// protect pin counts only while quad enable is clear
assign wp_lock = swd && !qe && !lane_s[2];

// quad mode needs quad enable, since it borrows two pins
assign mode_raw = control[`CTL_MODE_HI:`CTL_MODE_LO];
assign mode = (mode_raw == `MODE_QUAD && !qe) ? `MODE_SINGLE : mode_raw;
assign step = (mode == `MODE_QUAD) ? 3'h4 : (mode == `MODE_DUAL) ? 3'h2 : 3'h1;

// ----------------------------------------
// frame state machine
// ----------------------------------------
always @*
begin
   next_state = state;
   case (state)
      S_IDLE:
      begin
         if (reset_req)
            next_state = S_RESET;
         else if (sel_fall)
            next_state = S_ACTIVE;
      end
      S_ACTIVE:
      begin
         if (reset_req)
            next_state = S_RESET;
         else if (sel_n_s)
            next_state = S_IDLE;
         else if (hold_req)
            next_state = S_PAUSED;
      end
      S_PAUSED:
      begin
         if (reset_req)
            next_state = S_RESET;
         else if (sel_n_s)
            next_state = S_IDLE;
         else if (!hold_req)
            next_state = S_ACTIVE;
      end
      S_RESET:
      begin
         // leave only when every reset source is released
         if (!reset_req)
            next_state = S_IDLE;
      end
      default:
      begin
         next_state = S_IDLE;
      end
   endcase
end

always @(posedge i_sys_clk or negedge i_resetn)
begin
   if (!i_resetn)
      state <= S_IDLE;
   else if (i_ce)
      state <= next_state;
end

// ----------------------------------------
// shifter control
// ----------------------------------------
// edges count only while active; pause leaves counters alone
assign shift_clear = (state != S_ACTIVE) && (state != S_PAUSED);
assign sample_en = (state == S_ACTIVE) && !hold_req && sck_rise;
// in clock-idles-high use the first fall precedes any rise
assign advance_en = (state == S_ACTIVE) && !hold_req && sck_fall && seen_rise;

always @(posedge i_sys_clk or negedge i_resetn)
begin
   if (!i_resetn)
      seen_rise <= 1'b0;
   else if (i_ce)
   begin
      if (shift_clear)
         seen_rise <= 1'b0;
      else if (sample_en)
         seen_rise <= 1'b1;
   end
end

lane_shifter u_shift
(
   .i_sys_clk(i_sys_clk),
   .i_resetn(i_resetn),
   .i_ce(i_ce),
   .i_clear(shift_clear),
   .i_sample(sample_en),
   .i_advance(advance_en),
   .i_step(step),
   .i_load_data(tx_data),
   .i_lanes(lane_s),
   .o_rx_byte(rx_byte),
   .o_rx_done(rx_done),
   .o_tx_bits(tx_bits)
);

// ----------------------------------------
// lane drivers
// ----------------------------------------
assign drive = (state == S_ACTIVE) && control[`CTL_DIR_BIT];

generate
   genvar g;
   for (g = 0; g < 4; g = g + 1)
   begin : g_lane
      always @*
      begin
         next_oe[g] = 1'b0;
         next_out[g] = 1'b0;
         case (mode)
            `MODE_DUAL:
            begin
               // lane one carries the higher bit
               next_oe[g] = drive && (g < 2);
               next_out[g] = (g < 2) ? tx_bits[(g + 2) % 4] : 1'b0;
            end
            `MODE_QUAD:
            begin
               next_oe[g] = drive;
               next_out[g] = tx_bits[g];
            end
            default:
            begin
               // single lane: output pin only
               next_oe[g] = drive && (g == 1);
               next_out[g] = (g == 1) ? tx_bits[3] : 1'b0;
            end
         endcase
      end
   end
endgenerate

always @(posedge i_sys_clk or negedge i_resetn)
begin
   if (!i_resetn)
   begin
      o_data_lane_oe <= 4'h0;
      o_data_lane_out <= 4'h0;
      o_rx_strobe <= 1'b0;
   end
   else if (i_ce)
   begin
      o_data_lane_oe <= next_oe;
      o_data_lane_out <= next_out;
      o_rx_strobe <= rx_done;
   end
end

// ----------------------------------------
// register writes
// ----------------------------------------
always @(posedge i_sys_clk or negedge i_resetn)
begin
   if (!i_resetn)
   begin
      status <= `STATUS_RESET;
      func <= `FUNC_RESET;
      control <= `CONTROL_RESET;
      tx_data <= `TX_RESET;
   end
   else if (i_ce && i_wr)
   begin
      case (i_addr)
         `ADDR_STATUS:
         begin
            // locked writes leave every protected bit as it was
            if (!wp_lock)
               status <= i_wdata & `STATUS_WMASK;
         end
         `ADDR_FUNCTION:
            func <= i_wdata;
         `ADDR_CONTROL:
            control <= i_wdata;
         `ADDR_TX_DATA:
            tx_data <= i_wdata;
         default:
            tx_data <= tx_data;
      endcase
   end
end

// ----------------------------------------
// sticky flags, a set beats a clear
// ----------------------------------------
always @(posedge i_sys_clk or negedge i_resetn)
begin
   if (!i_resetn)
   begin
      rx_data <= 8'h00;
      rx_full <= 1'b0;
      refused <= 1'b0;
   end
   else if (i_ce)
   begin
      if (rx_done)
      begin
         rx_data <= rx_byte;
         rx_full <= 1'b1;
      end
      else if (i_rd && i_addr == `ADDR_RX_DATA)
         rx_full <= 1'b0;
      if (i_wr && i_addr == `ADDR_STATUS && wp_lock)
         refused <= 1'b1;
      else if (i_rd && i_addr == `ADDR_PIN_STATE)
         refused <= 1'b0;
   end
end

// ----------------------------------------
// register reads, data one cycle after the strobe
// ----------------------------------------
always @*
begin
   next_rdata = 8'h00;
   case (i_addr)
      `ADDR_STATUS: next_rdata = status;
      `ADDR_FUNCTION: next_rdata = func;
      `ADDR_CONTROL: next_rdata = control;
      `ADDR_TX_DATA: next_rdata = tx_data;
      `ADDR_RX_DATA: next_rdata = rx_data;
      `ADDR_PIN_STATE:
      begin
         next_rdata[`PS_SELECTED_BIT] = (state == S_ACTIVE) || (state == S_PAUSED);
         next_rdata[`PS_PAUSED_BIT] = (state == S_PAUSED);
         next_rdata[`PS_RESET_BIT] = (state == S_RESET);
         next_rdata[`PS_RX_FULL_BIT] = rx_full;
         next_rdata[`PS_REFUSED_BIT] = refused;
      end
      default: next_rdata = 8'h00;
   endcase
end

always @(posedge i_sys_clk or negedge i_resetn)
begin
   if (!i_resetn)
      o_rdata <= 8'h00;
   else if (i_ce)
      o_rdata <= i_rd ? next_rdata : 8'h00;
end

endmodule // flash_pin_front_end

// ### test/flash_front_asserts.sv
`timescale 1ns/1ps

// ----------------------------------------
// port checker
// ----------------------------------------
module flash_front_asserts
(
   // clock and reset
   input wire i_sys_clk,
   input wire i_resetn,
   // link pins
   input wire i_sck,
   input wire i_select_n,
   input wire [3:0] o_data_lane_out,
   input wire [3:0] o_data_lane_oe,
   // register port and strobe
   input wire i_rd,
   input wire [7:0] o_rdata,
   input wire o_rx_strobe
);
   logic [3:0] since_fall; // cycles since link clock fell
   logic [3:0] since_rise; // cycles since link clock rose
   logic fell_seen; // select fell since reset

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_resetn);

   // ages saturate so a stopped link clock never wraps round
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         since_fall <= 4'hF;
         since_rise <= 4'hF;
         fell_seen <= 1'b0;
      end
      else
      begin
         since_fall <= $fell(i_sck) ? 4'h0 : since_fall + {3'h0, since_fall != 4'hF};
         since_rise <= $rose(i_sck) ? 4'h0 : since_rise + {3'h0, since_rise != 4'hF};
         fell_seen <= fell_seen | $fell(i_select_n);
      end
   end

   desel_release_a: assert property (i_select_n [*6] |-> o_data_lane_oe == 4'h0)
      else $error("lanes driven while deselected");
   sel_gate_a: assert property ($rose(o_data_lane_oe[1]) |-> !i_select_n && !$past(i_select_n, 3))
      else $error("lane enable rose without select");
   desel_ignore_a: assert property (i_select_n [*8] |-> !o_rx_strobe)
      else $error("byte taken while deselected");
   first_fall_a: assert property (o_rx_strobe |-> fell_seen)
      else $error("byte taken before select fell");
   rise_sample_a: assert property (o_rx_strobe |-> since_rise inside {[4'h1:4'h5]})
      else $error("byte not ended by a rising edge");
   strobe_pulse_a: assert property (o_rx_strobe |=> !o_rx_strobe [*3])
      else $error("strobe too long");
   fall_drive_a: assert property ($changed(o_data_lane_out[1]) && o_data_lane_oe[1]
      && $past(o_data_lane_oe[1]) |-> since_fall inside {[4'h2:4'h6]})
      else $error("output bit moved off a falling edge");
   rd_quiet_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data without a read");
endmodule // flash_front_asserts

bind flash_pin_front_end flash_front_asserts u_chk
(
   .i_sys_clk(i_sys_clk),
   .i_resetn(i_resetn),
   .i_sck(i_sck),
   .i_select_n(i_select_n),
   .o_data_lane_out(o_data_lane_out),
   .o_data_lane_oe(o_data_lane_oe),
   .i_rd(i_rd),
   .o_rdata(o_rdata),
   .o_rx_strobe(o_rx_strobe)
);

// ### test/spi_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// link master model, clock idles low
// ----------------------------------------
module spi_host_model
(
   // pacing clock
   input wire i_sys_clk,
   // device lane drive
   input wire [3:0] i_dev_out,
   input wire [3:0] i_dev_oe,
   // link pins
   output logic o_sck,
   output logic o_select_n,
   output logic [3:0] o_wire
);
   logic [3:0] lane = 4'hC; // master levels, protect and hold high
   logic [3:0] lane_oe = 4'hD; // lane 1 is the device's in single mode
   logic [7:0] rx_sh; // bits read from lane 1
   logic flip = 1'b0; // undriven lanes toggle so stale data never passes

   initial o_sck = 1'b0;
   initial o_select_n = 1'b0; // low through power-up on purpose
   always @(posedge i_sys_clk) flip <= ~flip;
   // device first, then master, else the moving pattern
   assign o_wire = (i_dev_oe & i_dev_out) | (~i_dev_oe & lane_oe & lane) | (~i_dev_oe & ~lane_oe & {4{flip}});

   // select change, then a gap before the clock runs
   task automatic sel(input logic v);
      @(posedge i_sys_clk) o_select_n <= v;
      repeat (8) @(posedge i_sys_clk);
   endtask

   // protect and hold levels
   task automatic pins(input logic wp, input logic hold_n);
      @(posedge i_sys_clk) lane[3:2] <= {hold_n, wp};
      repeat (4) @(posedge i_sys_clk);
   endtask

   // msb first, n lanes a step; bits read late in the high phase
   task automatic xfer(input logic [7:0] tx, input int n, input int bits);
      logic [7:0] sh;
      sh = tx;
      for (int i = 0; i < bits; i += n)
      begin
         @(posedge i_sys_clk);
         lane_oe <= (n == 1) ? 4'hD : 4'hF;
         lane <= (n == 4) ? sh[7:4] : (n == 2) ? {lane[3:2], sh[7:6]} : {lane[3:2], 1'b0, sh[7]};
         repeat (3) @(posedge i_sys_clk);
         o_sck <= 1'b1;
         repeat (3) @(posedge i_sys_clk);
         @(negedge i_sys_clk) rx_sh = {rx_sh[6:0], o_wire[1]};
         @(posedge i_sys_clk) o_sck <= 1'b0;
         sh = sh << n;
      end
   endtask

   // bare clock pulses
   task automatic ticks(input int k);
      repeat (k)
      begin
         repeat (4) @(posedge i_sys_clk);
         o_sck <= 1'b1;
         repeat (4) @(posedge i_sys_clk);
         o_sck <= 1'b0;
      end
   endtask
endmodule // spi_host_model

// ### test/tb_top.sv
`timescale 1ns/1ps
`include "flash_front_consts.vh"

`define CHK(got, exp) \
   begin \
      checks++; \
      if ((got) !== (exp)) \
      begin \
         err_total++; \
         $display("[ERR] %0t got %h exp %h", $time, got, exp); \
      end \
   end

module tb_top;
   logic i_sys_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_reset_pin_n;
   logic [3:0] i_addr;
   logic [7:0] i_wdata;
   logic i_wr, i_rd, ce;
   wire i_sck;
   wire i_select_n;
   wire [3:0] lanes;
   wire [3:0] dev_out;
   wire [3:0] dev_oe;
   wire [7:0] o_rdata;
   wire o_rx_strobe;
   int err_total = 0;
   int checks = 0;
   int strobes = 0; // bytes seen at the port
   int exp_strobes = 0; // bytes the model expects
   logic [7:0] q[$]; // expected received bytes
   logic [7:0] b, v, w, s;

   initial forever #50 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) if (o_rx_strobe === 1'b1) strobes++;

   flash_pin_front_end DUT
   (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_ce(ce),
      .i_sck(i_sck),
      .i_select_n(i_select_n),
      .i_reset_pin_n(i_reset_pin_n),
      .i_data_lane_in(lanes),
      .o_data_lane_out(dev_out),
      .o_data_lane_oe(dev_oe),
      .i_addr(i_addr),
      .i_wdata(i_wdata),
      .i_wr(i_wr),
      .i_rd(i_rd),
      .o_rdata(o_rdata),
      .o_rx_strobe(o_rx_strobe)
   );

   spi_host_model u_host
   (
      .i_sys_clk(i_sys_clk),
      .i_dev_out(dev_out),
      .i_dev_oe(dev_oe),
      .o_sck(i_sck),
      .o_select_n(i_select_n),
      .o_wire(lanes)
   );

   // ----------------------------------------
   // register port and helpers
   // ----------------------------------------
   task automatic idle(input int k);
      repeat (k) @(posedge i_sys_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge i_sys_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      @(negedge i_sys_clk) d = o_rdata;
   endtask
   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      `CHK(d, e)
   endtask
   task automatic rbit(input logic e);
      logic [7:0] d;
      idle(6);
      rd(`ADDR_PIN_STATE, d);
      `CHK(d[`PS_RESET_BIT], e)
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // hang guard, far beyond the expected run
   initial
   begin
      #2_000_000;
      err_total++;
      complete_run();
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      void'($urandom(32'h6b24cded));
      {i_reset_pin_n, i_wr, i_rd, ce} <= 4'b1001;
      {i_addr, i_wdata} <= 12'($urandom);
      idle(8);
      i_resetn <= 1'b1;
      idle(2);
      ce <= 1'b0; // frozen: this write must not land
      wr(`ADDR_CONTROL, 8'h0F);
      ce <= 1'b1;
      // select low since power-up: the byte must be ignored
      u_host.xfer(8'hA5, 1, 8);
      idle(8);
      `CHK(strobes, 0)
      `CHK(dev_oe, 4'h0)
      rc(`ADDR_STATUS, `STATUS_RESET);
      rc(`ADDR_FUNCTION, `FUNC_RESET);
      rc(`ADDR_CONTROL, `CONTROL_RESET);
      rc(`ADDR_TX_DATA, `TX_RESET);
      rc(4'hF, 8'h00);
      $display("test 1 done");
      // clocks while deselected, then bytes in one frame
      u_host.sel(1'b1);
      u_host.ticks(9);
      `CHK(strobes, 0)
      u_host.sel(1'b0);
      repeat (4)
      begin
         b = 8'($urandom);
         q.push_back(b);
         exp_strobes++;
         u_host.xfer(b, 1, 8);
         idle(6);
         `CHK(strobes, exp_strobes)
         rc(`ADDR_RX_DATA, q.pop_front());
      end
      u_host.sel(1'b1);
      $display("test 2 done");
      // read back, second byte reloaded mid-frame
      v = 8'($urandom);
      w = 8'($urandom);
      wr(`ADDR_CONTROL, 8'h08);
      wr(`ADDR_TX_DATA, v);
      u_host.sel(1'b0);
      wr(`ADDR_TX_DATA, w);
      u_host.xfer(8'h00, 1, 8);
      `CHK(u_host.rx_sh, v)
      u_host.xfer(8'h00, 1, 8);
      `CHK(u_host.rx_sh, w)
      u_host.sel(1'b1);
      exp_strobes += 2;
      $display("test 3 done");
      // dual and quad, lane 3 low at the first quad step
      wr(`ADDR_CONTROL, 8'h00);
      wr(`ADDR_STATUS, 8'h40);
      for (int n = 2; n <= 4; n += 2)
      begin
         wr(`ADDR_CONTROL, (n == 2) ? 8'h02 : 8'h04);
         b = 8'($urandom) & 8'h7F;
         u_host.sel(1'b0);
         u_host.xfer(b, n, 8);
         idle(6);
         u_host.sel(1'b1);
         rc(`ADDR_RX_DATA, b);
      end
      exp_strobes += 2;
      $display("test 4 done");
      // status lock over protect level and quad enable
      for (int c = 0; c < 4; c++)
      begin
         u_host.pins(1'b1, 1'b1);
         s = {1'b1, c[1], 6'h00};
         wr(`ADDR_STATUS, s);
         u_host.pins(c[0], 1'b1);
         b = {1'b1, c[1], 6'($urandom)};
         wr(`ADDR_STATUS, b);
         if (c[0] || c[1])
            s = b & `STATUS_WMASK;
         rc(`ADDR_STATUS, s);
         rd(`ADDR_PIN_STATE, v);
         `CHK(v[`PS_REFUSED_BIT], !(c[0] || c[1]))
      end
      u_host.pins(1'b1, 1'b1);
      wr(`ADDR_STATUS, 8'h00);
      u_host.pins(1'b0, 1'b1);
      b = 8'($urandom) & 8'h3C;
      wr(`ADDR_STATUS, b);
      rc(`ADDR_STATUS, b);
      $display("test 5 done");
      // pause mid-byte, control pin-function bit set but reset pin enabled
      v = 8'($urandom);
      b = 8'($urandom);
      wr(`ADDR_CONTROL, 8'h09);
      wr(`ADDR_TX_DATA, v);
      u_host.sel(1'b0);
      u_host.xfer(b, 1, 4);
      u_host.pins(1'b1, 1'b0);
      rd(`ADDR_PIN_STATE, s);
      `CHK(dev_oe[1], 1'b0)
      `CHK(s[2:1], 2'b01)
      u_host.ticks(3);
      u_host.pins(1'b1, 1'b1);
      u_host.xfer(b << 4, 1, 4);
      idle(6);
      `CHK(u_host.rx_sh, v)
      rc(`ADDR_RX_DATA, b);
      exp_strobes++;
      $display("test 6 done");
      // reset by dedicated pin, then by the fourth lane
      `CHK(dev_oe[1], 1'b1)
      i_reset_pin_n <= 1'b0;
      idle(6);
      `CHK(dev_oe, 4'h0)
      rbit(1'b1);
      i_reset_pin_n <= 1'b1;
      rbit(1'b0);
      wr(`ADDR_FUNCTION, 8'h01);
      i_reset_pin_n <= 1'b0;
      rbit(1'b0);
      i_reset_pin_n <= 1'b1;
      u_host.pins(1'b1, 1'b0);
      rbit(1'b1);
      wr(`ADDR_CONTROL, 8'h08);
      rbit(1'b0);
      u_host.pins(1'b1, 1'b1);
      u_host.sel(1'b1);
      `CHK(strobes, exp_strobes)
      $display("test 7 done");
      complete_run();
   end
endmodule // tb_top
